// File: upr_pkg.sv
package upr_pkg;
    // Register map, word addresses on the plain port
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_CFG    = 4'h1;
    // Control word bit positions
    localparam int RESP_LSB   = 0;
    localparam int BUSY_BIT   = 5;
    localparam int TOG_BIT    = 6;
    localparam int FONE_BIT   = 7;
    localparam int FZERO_BIT  = 8;
    localparam int CLR_BIT    = 9;
    localparam int AUTO_BIT   = 10;
    localparam int PEND_BIT   = 14;
    localparam int STAT_BIT   = 15;
    // Config word bit positions
    localparam int DIR_BIT    = 0;
    localparam int DBL_BIT    = 1;
    localparam int BUFFER_READY_ON_READ_END_BIT   = 2;
    localparam int HOST_BIT   = 3;
    // Response selection codes
    localparam logic [1:0] RESP_NAK    = 2'h0;
    localparam logic [1:0] RESP_BUF    = 2'h1;
    localparam logic [1:0] RESP_STALL2 = 2'h2;
    localparam logic [1:0] RESP_STALL3 = 2'h3;
    // Handshake answers to a function-mode token
    localparam logic [1:0] HS_NAK   = 2'h0;
    localparam logic [1:0] HS_ACK   = 2'h1;
    localparam logic [1:0] HS_STALL = 2'h2;
    localparam logic [1:0] HS_DATA  = 2'h3;
    localparam logic [1:0] ERR_LIMIT = 2'h3;
    localparam logic [15:0] CTRL_RST = 16'h0000;
endpackage : upr_pkg

// File: upr_plane_mon.sv
`timescale 1ns/100ps
// Tracks filled buffer planes of one pipe
module upr_plane_mon (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       clear_in,
    input  wire logic       dbl_in,
    input  wire logic       fill_done_in,
    input  wire logic       sent_done_in,
    output logic      [1:0] planes_out
);
    typedef struct packed {
        logic [1:0] cnt;
    } upr_pm_t;
    upr_pm_t st_reg;
    upr_pm_t st_next;
    logic [1:0] cap;
    always_comb begin
        st_next = st_reg;
        cap = dbl_in ? 2'd2 : 2'd1;
        if (clear_in) begin
            st_next.cnt = 2'd0;
        end else begin
            if (fill_done_in && !sent_done_in && st_reg.cnt < cap)
                st_next.cnt = st_reg.cnt + 2'd1;
            if (sent_done_in && !fill_done_in && st_reg.cnt != 2'd0)
                st_next.cnt = st_reg.cnt - 2'd1;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign planes_out = st_reg.cnt;
endmodule : upr_plane_mon

// File: upr_pipe_ctrl.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
//
// Contract
// - Transmit pipe: pending flag set once a plane is fully written.
// - Pending flag clears when written planes are sent; both in double mode.
// - Receive pipe: pending flag mirrors buffer access status.
// - Host mode: NAK or STALL selection issues no tokens.
// - Host mode: buffer response issues tokens only if bus active and ready.
// - Function mode: NAK selection always answers NAK, auto response or not.
// - Function mode: receive pipe with buffer response ACKs when ready.
// - Function mode: transmit pipe sends data when ready, else NAK.
// - Function mode: STALL selection answers STALL.
// - Writing 1 then 0 to buffer clear resets planes, flags, error count.
// - Transmit status: 1 while writable, 0 once written; no read-end flag.
// - Receive status: 1 while readable; with read-end flag drops on clear.
// - Response selection resets to NAK; 00 NAK, 01 buffer, 1x STALL.
// - Oversize data packet forces response selection to STALL 11 unless a function mode bus reset comes in the same cycle.
// - Function mode bus reset forces response selection to NAK.
// - Host: three receive errors force NAK; STALL handshake forces 11.
// - Busy flag rises at transaction start, falls at its completion.
// - Toggle flips on completion, holds on receive data PID mismatch.
// - Force-one/zero bits set DATA1/DATA0 and always read zero.
// - Auto response bulk IN: zero-length packets, toggle on ACK, no events.
// - Auto response bulk OUT: NAK and raise not-ready event.
//
module upr_pipe_ctrl (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    // Buffer side
    input  wire logic        fill_done_in,
    input  wire logic        sent_done_in,
    input  wire logic        read_done_in,
    input  wire logic        buffer_clear_cmd_in,
    output logic             buffer_clear_out,
    // Link side
    input  wire logic        host_bus_active_in,
    input  wire logic        bus_reset_in,
    input  wire logic        token_in,
    input  wire logic        trans_done_in,
    input  wire logic        rx_pid_in,
    input  wire logic        rx_error_in,
    input  wire logic        rx_ok_in,
    input  wire logic        rx_oversize_in,
    input  wire logic        rx_stall_in,
    input  wire logic        bulk_in,
    output logic             token_issue_out,
    output logic             answer_valid_out,
    output logic      [1:0]  answer_out,
    output logic             zero_len_out,
    output logic             not_ready_event_out,
    output logic             buffer_ready_event_out,
    output logic             buffer_empty_event_out
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0]  resp;
        logic        busy;
        logic        tog;
        logic        clr;
        logic        auto_rsp;
        logic        dir;
        logic        dbl;
        logic        buffer_ready_on_read_end;
        logic        host;
        logic        rx_hold;
        logic [1:0]  errs;
        logic        ans_v;
        logic [1:0]  ans;
        logic        zlp;
        logic        not_ready_event;
        logic        buffer_ready_event;
        logic        buffer_empty_event;
        logic [15:0] rdata;
    } upr_st_t;

    upr_st_t st_reg;
    upr_st_t st_next;
    logic [1:0] planes;
    logic       clear_pulse;
    logic       pending;
    logic       status;
    logic       ready;
    logic       wr_ctrl;
    logic       wr_cfg;
    localparam logic [1:0] ERR_LAST = upr_pkg::ERR_LIMIT - 2'd1;

    ////////////////////////////////////////////////////////////////////////
    // Falling edge of the clear bit empties the buffer state
    assign clear_pulse = wr_ctrl && st_reg.clr
                         && !reg_wdata_in[upr_pkg::CLR_BIT];

    upr_plane_mon u_plane_mon (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .clear_in     (clear_pulse),
        .dbl_in       (st_reg.dbl),
        .fill_done_in (fill_done_in && st_reg.dir),
        .sent_done_in (sent_done_in && st_reg.dir),
        .planes_out   (planes)
    );

    assign wr_ctrl = reg_wr_in && reg_addr_in == upr_pkg::ADDR_CTRL;
    assign wr_cfg  = reg_wr_in && reg_addr_in == upr_pkg::ADDR_CFG;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // status by direction and double-plane mode
        if (st_reg.dir)
            status = st_reg.dbl ? (planes != 2'd2) : (planes == 2'd0);
        else
            status = st_reg.rx_hold;
        pending = st_reg.dir ? (planes != 2'd0) : status;
        ready = st_reg.dir ? pending : !st_reg.rx_hold;
    end

    always_comb begin
        st_next = st_reg;
        st_next.ans_v = 1'b0;
        st_next.zlp   = 1'b0;
        st_next.not_ready_event  = 1'b0;
        st_next.buffer_ready_event  = 1'b0;
        st_next.buffer_empty_event  = 1'b0;
        st_next.rdata = 16'h0000;
        // Register writes
        if (wr_ctrl) begin
            st_next.resp     = reg_wdata_in[upr_pkg::RESP_LSB +: 2];
            st_next.clr      = reg_wdata_in[upr_pkg::CLR_BIT];
            st_next.auto_rsp = reg_wdata_in[upr_pkg::AUTO_BIT];
            if (reg_wdata_in[upr_pkg::FONE_BIT])
                st_next.tog = 1'b1;
            else if (reg_wdata_in[upr_pkg::FZERO_BIT])
                st_next.tog = 1'b0;
        end
        if (wr_cfg) begin
            st_next.dir  = reg_wdata_in[upr_pkg::DIR_BIT];
            st_next.dbl  = reg_wdata_in[upr_pkg::DBL_BIT];
            st_next.buffer_ready_on_read_end = reg_wdata_in[upr_pkg::BUFFER_READY_ON_READ_END_BIT];
            st_next.host = reg_wdata_in[upr_pkg::HOST_BIT];
        end
        // Receive buffer holding data
        if (!st_reg.dir) begin
            if (rx_ok_in)
                st_next.rx_hold = 1'b1;
            else if (st_reg.buffer_ready_on_read_end ? buffer_clear_cmd_in : read_done_in)
                st_next.rx_hold = 1'b0;
        end
        if (clear_pulse) begin
            if (!rx_ok_in || st_reg.dir)
                st_next.rx_hold = 1'b0;
            st_next.errs = 2'd0;
        end
        // Function mode token answer
        if (token_in && !st_reg.host) begin
            st_next.ans_v = 1'b1;
            st_next.busy  = 1'b1;
            case (st_reg.resp)
                upr_pkg::RESP_NAK: begin
                    st_next.ans = upr_pkg::HS_NAK;
                end
                upr_pkg::RESP_BUF: begin
                    if (st_reg.auto_rsp && bulk_in && st_reg.dir) begin
                        st_next.ans = upr_pkg::HS_DATA;
                        st_next.zlp = 1'b1;
                    end else if (st_reg.auto_rsp && bulk_in) begin
                        st_next.ans  = upr_pkg::HS_NAK;
                        st_next.not_ready_event = 1'b1;
                    end else if (st_reg.dir) begin
                        st_next.ans = ready ? upr_pkg::HS_DATA
                                            : upr_pkg::HS_NAK;
                        st_next.not_ready_event = !ready;
                    end else begin
                        st_next.ans = !st_reg.rx_hold ? upr_pkg::HS_ACK
                                                      : upr_pkg::HS_NAK;
                        st_next.not_ready_event = st_reg.rx_hold;
                    end
                end
                default: begin
                    st_next.ans = upr_pkg::HS_STALL;
                end
            endcase
        end
        if (st_reg.host && token_issue_out)
            st_next.busy = 1'b1;
        // Completion of one transaction
        if (trans_done_in && st_reg.busy) begin
            st_next.busy = token_in && !st_reg.host;
            if (st_reg.dir || rx_pid_in == st_reg.tog)
                st_next.tog = !st_reg.tog;
            if (!st_reg.auto_rsp) begin
                st_next.buffer_ready_event = st_reg.dir ? 1'b0 : 1'b1;
                st_next.buffer_empty_event = st_reg.dir;
            end
        end
        // Host receive errors and handshakes, then oversize and function mode bus reset overrides
        if (st_reg.host && rx_error_in) begin
            st_next.errs = st_reg.errs + 2'd1;
            if (st_reg.errs == ERR_LAST)
                st_next.resp = upr_pkg::RESP_NAK;
        end else if (st_reg.host && rx_ok_in) begin
            st_next.errs = 2'd0;
        end
        if (st_reg.host && rx_stall_in)
            st_next.resp = upr_pkg::RESP_STALL3;
        if (rx_oversize_in)
            st_next.resp = upr_pkg::RESP_STALL3;
        if (!st_reg.host && bus_reset_in)
            st_next.resp = upr_pkg::RESP_NAK;
        // Read data, write-only bits read as zero
        if (reg_rd_in && reg_addr_in == upr_pkg::ADDR_CTRL) begin
            st_next.rdata[upr_pkg::RESP_LSB +: 2] = st_reg.resp;
            st_next.rdata[upr_pkg::BUSY_BIT]  = st_reg.busy;
            st_next.rdata[upr_pkg::TOG_BIT]   = st_reg.tog;
            st_next.rdata[upr_pkg::CLR_BIT]   = st_reg.clr;
            st_next.rdata[upr_pkg::AUTO_BIT]  = st_reg.auto_rsp;
            st_next.rdata[upr_pkg::PEND_BIT]  = pending;
            st_next.rdata[upr_pkg::STAT_BIT]  = status;
        end else if (reg_rd_in && reg_addr_in == upr_pkg::ADDR_CFG) begin
            st_next.rdata[upr_pkg::DIR_BIT]  = st_reg.dir;
            st_next.rdata[upr_pkg::DBL_BIT]  = st_reg.dbl;
            st_next.rdata[upr_pkg::BUFFER_READY_ON_READ_END_BIT] = st_reg.buffer_ready_on_read_end;
            st_next.rdata[upr_pkg::HOST_BIT] = st_reg.host;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Host token gating
    assign token_issue_out = st_reg.host && !st_reg.busy
                             && st_reg.resp == upr_pkg::RESP_BUF
                             && host_bus_active_in
                             && ready;
    assign buffer_clear_out       = clear_pulse;
    assign reg_rdata_out          = st_reg.rdata;
    assign answer_valid_out       = st_reg.ans_v;
    assign answer_out             = st_reg.ans;
    assign zero_len_out           = st_reg.zlp;
    assign not_ready_event_out    = st_reg.not_ready_event;
    assign buffer_ready_event_out = st_reg.buffer_ready_event;
    assign buffer_empty_event_out = st_reg.buffer_empty_event;

    ////////////////////////////////////////////////////////////////////////
    property p_reset_nak;
        @(posedge sys_clk_in) $rose(rst_in) |=> st_reg.resp == 2'h0;
    endproperty
    a_reset_nak: assert property (p_reset_nak)
        else $error("Response not NAK after reset");

    property p_no_token_idle;
        @(posedge sys_clk_in) disable iff (rst_in)
            st_reg.resp != upr_pkg::RESP_BUF |-> !token_issue_out;
    endproperty
    a_no_token_idle: assert property (p_no_token_idle)
        else $error("Token issued without buffer response");

    property p_token_active;
        @(posedge sys_clk_in) disable iff (rst_in)
            token_issue_out |-> host_bus_active_in && st_reg.host;
    endproperty
    a_token_active: assert property (p_token_active)
        else $error("Token issued while bus inactive");

    property p_stall_answer;
        @(posedge sys_clk_in) disable iff (rst_in)
            token_in && !st_reg.host && st_reg.resp[1] && !rx_oversize_in
            |=> answer_valid_out && answer_out == upr_pkg::HS_STALL;
    endproperty
    a_stall_answer: assert property (p_stall_answer)
        else $error("STALL selection did not answer STALL");

    property p_nak_answer;
        @(posedge sys_clk_in) disable iff (rst_in)
            token_in && !st_reg.host && st_reg.resp == upr_pkg::RESP_NAK
            |=> answer_out == upr_pkg::HS_NAK;
    endproperty
    a_nak_answer: assert property (p_nak_answer)
        else $error("NAK selection did not answer NAK");

    property p_tx_data;
        @(posedge sys_clk_in) disable iff (rst_in)
            token_in && !st_reg.host && st_reg.resp == upr_pkg::RESP_BUF
            && st_reg.dir && !st_reg.auto_rsp && pending
            |=> answer_out == upr_pkg::HS_DATA;
    endproperty
    a_tx_data: assert property (p_tx_data)
        else $error("Ready transmit pipe did not send data");

    property p_oversize;
        @(posedge sys_clk_in) disable iff (rst_in)
            rx_oversize_in && !(bus_reset_in && !st_reg.host)
            |=> st_reg.resp == upr_pkg::RESP_STALL3;
    endproperty
    a_oversize: assert property (p_oversize)
        else $error("Oversize packet did not force STALL");

    property p_bus_reset;
        @(posedge sys_clk_in) disable iff (rst_in)
            bus_reset_in && !st_reg.host |=> st_reg.resp == upr_pkg::RESP_NAK;
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("Bus reset did not force NAK");

    property p_busy_fall;
        @(posedge sys_clk_in) disable iff (rst_in)
            trans_done_in && st_reg.busy && !token_in |=> !st_reg.busy;
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("Busy flag stuck after completion");

    property p_tog_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
            trans_done_in && st_reg.busy && !st_reg.dir && !wr_ctrl
            && rx_pid_in != st_reg.tog |=> $stable(st_reg.tog);
    endproperty
    a_tog_hold: assert property (p_tog_hold)
        else $error("Toggle moved on data PID mismatch");

    property p_force_read_zero;
        @(posedge sys_clk_in) disable iff (rst_in)
            reg_rd_in |=> !reg_rdata_out[upr_pkg::FONE_BIT]
                          && !reg_rdata_out[upr_pkg::FZERO_BIT];
    endproperty
    a_force_read_zero: assert property (p_force_read_zero)
        else $error("Force bits read as one");

    property p_pend_mirror;
        @(posedge sys_clk_in) disable iff (rst_in)
            !st_reg.dir |-> pending == status;
    endproperty
    a_pend_mirror: assert property (p_pend_mirror)
        else $error("Receive pending differs from status");

    c_zlp:   cover property (@(posedge sys_clk_in) zero_len_out);
    c_stall: cover property (@(posedge sys_clk_in) rx_stall_in && st_reg.host);
    c_clear: cover property (@(posedge sys_clk_in) clear_pulse);
    c_tok:   cover property (@(posedge sys_clk_in) token_issue_out);
endmodule : upr_pipe_ctrl

// File: upr_usb_peer.sv
`timescale 1ns/100ps
// Far side of the link: raises one-cycle event pulses on command
module upr_usb_peer (
    input  wire logic       sys_clk_in,
    input  wire logic [6:0] req_in,
    input  wire logic       pid_in,
    output logic            token_out,
    output logic            done_out,
    output logic            pid_out,
    output logic            err_out,
    output logic            ok_out,
    output logic            big_out,
    output logic            stall_out,
    output logic            breset_out
);
    // Pulse index: 0 token, 1 done, 2 error, 3 good data,
    // 4 oversize, 5 stall handshake, 6 bus reset
    logic [6:0] pulse_reg;
    logic       pid_reg;
    ////////////////////////////////////////////////////////////
    // Events leave on the rising edge after the bench asks
    always_ff @(posedge sys_clk_in) begin
        pulse_reg <= req_in;
        pid_reg   <= pid_in;
    end
    assign {breset_out, stall_out, big_out, ok_out} = pulse_reg[6:3];
    assign {err_out, done_out, token_out} = pulse_reg[2:0];
    assign pid_out = pid_reg;
endmodule : upr_usb_peer

// File: test_usb_pipe_response_control.sv
`timescale 1ns/100ps
module test_usb_pipe_response_control;
    typedef struct packed {
        logic       host;
        logic       dir;
        logic       bulk;
        logic       act;
        logic [3:0] fill;
        logic [1:0] resp;
        logic [1:0] exp;
    } upr_row_t;
    localparam logic [3:0] A_CT = upr_pkg::ADDR_CTRL;
    localparam logic [3:0] A_CF = upr_pkg::ADDR_CFG;
    logic        sys_clk_in = 1'h0;
    logic        rst_in = 1'h1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'h0;
    logic        reg_rd = 1'h0;
    logic [15:0] rdata;
    logic [3:0]  bufp = 4'h0;
    logic        host_act = 1'h0;
    logic        bulk = 1'h1;
    logic [6:0]  preq = 7'h00;
    logic        ppid = 1'h0;
    logic        tok, done, pid, err, ok, big, stl, brst;
    logic        clr_o, issue, ans_v, zl, not_ready_event, buffer_ready_event, buffer_empty_event;
    logic [1:0]  ans;
    logic [4:0]  ev;
    int          num_errors = 0;
    int          tests_run = 0;
    int          ev_cnt [5] = '{default: 0};
    int          ev_base [5];
    upr_row_t    r;
    // Mode nibble, fill, {resp, answer code or issue flag}
    upr_row_t    rows [15] = '{12'h600, 12'h617, 12'h604, 12'h205,
        12'h00a, 12'h60e, 12'h000, 12'hf10, 12'hb08, 12'hf1c, 12'hf15,
        12'he14, 12'hf04, 12'hb05, 12'h905};

    always #5 sys_clk_in = ~sys_clk_in;
    assign ev = {clr_o, buffer_empty_event, buffer_ready_event, not_ready_event, zl};
    always @(posedge sys_clk_in) begin
        for (int k = 0; k < 5; k++) if (ev[k] === 1'h1) ev_cnt[k]++;
    end

    upr_pipe_ctrl dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .fill_done_in(bufp[0]), .sent_done_in(bufp[1]),
        .read_done_in(bufp[2]), .buffer_clear_cmd_in(bufp[3]),
        .buffer_clear_out(clr_o), .host_bus_active_in(host_act),
        .bus_reset_in(brst), .token_in(tok), .trans_done_in(done),
        .rx_pid_in(pid), .rx_error_in(err), .rx_ok_in(ok),
        .rx_oversize_in(big), .rx_stall_in(stl), .bulk_in(bulk),
        .token_issue_out(issue), .answer_valid_out(ans_v),
        .answer_out(ans), .zero_len_out(zl),
        .not_ready_event_out(not_ready_event), .buffer_ready_event_out(buffer_ready_event),
        .buffer_empty_event_out(buffer_empty_event)
    );
    upr_usb_peer peer (
        .sys_clk_in(sys_clk_in), .req_in(preq), .pid_in(ppid),
        .token_out(tok), .done_out(done),
        .pid_out(pid), .err_out(err), .ok_out(ok), .big_out(big),
        .stall_out(stl), .breset_out(brst)
    );
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge sys_clk_in);
        reg_wr    <= 1'h0;
    endtask : wr
    task automatic rchk(input string what, input logic [3:0] a,
                        input logic [15:0] m, input logic [15:0] exp);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge sys_clk_in);
        reg_rd   <= 1'h0;
        #1;
        chk(what, exp, rdata & m);
    endtask : rchk
    task automatic bpulse(input int idx);
        @(posedge sys_clk_in);
        bufp <= 4'h1 << idx;
        @(posedge sys_clk_in);
        bufp <= 4'h0;
    endtask : bpulse
    // Far-side event; returns after the edge at which the design takes it
    task automatic strobe(input int idx);
        @(posedge sys_clk_in);
        preq <= 7'h01 << idx;
        @(posedge sys_clk_in);
        preq <= 7'h00;
        @(posedge sys_clk_in);
    endtask : strobe
    // Whole transaction; gap sets a prompt or slow completion
    task automatic xfer(input logic p, input logic good, input int gap);
        ppid <= p;
        strobe(0);
        if (good) strobe(3);
        repeat (gap) @(posedge sys_clk_in);
        strobe(1);
        ppid <= ~p;
    endtask : xfer
    task automatic reset_dut();
        @(posedge sys_clk_in);
        rst_in <= 1'h1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'h0;
    endtask : reset_dut
    task automatic snap();
        ev_base = ev_cnt;
    endtask : snap
    task automatic evchk(input string what, input int k,
                         input logic [15:0] exp);
        chk(what, exp, 16'(ev_cnt[k] - ev_base[k]));
    endtask : evchk
    // Token taken, answer checked in its single cycle, then completion
    task automatic tok_chk(input logic [1:0] exp);
        strobe(0);
        #1;
        chk("answer", {13'h0000, 1'h1, exp}, {13'h0000, ans_v, ans});
        strobe(1);
    endtask : tok_chk
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        print_verdict();
    end
    initial begin
        reset_dut();
        rchk("ctrl_rst", A_CT, 16'hffff, 16'h0000);
        wr(4'h7, 16'hffff);
        rchk("unmapped", 4'h7, 16'hffff, 16'h0000);
        rchk("ctrl_kept", A_CT, 16'hffff, 16'h0000);
        for (int i = 0; i < 15; i++) begin
            r = rows[i];
            reset_dut();
            host_act <= r.act;
            bulk     <= r.bulk;
            wr(A_CF, {12'h000, r.host, 2'h0, r.dir});
            if (r.fill[0]) bpulse(0);
            if (r.resp == 2'h3) wr(A_CT, 16'h0001);
            wr(A_CT, {14'h0000, r.resp});
            #1;
            if (r.host) chk("issue", {15'h0000, r.exp[0]}, {15'h0000, issue});
            else tok_chk(r.exp);
        end
        reset_dut();
        host_act <= 1'h0;
        bulk     <= 1'h1;
        wr(A_CF, 16'h0001);
        rchk("tx_idle", A_CT, 16'hc000, 16'h8000);
        bpulse(0);
        rchk("tx_full", A_CT, 16'hc000, 16'h4000);
        bpulse(1);
        rchk("tx_sent", A_CT, 16'hc000, 16'h8000);
        bpulse(0);
        snap();
        wr(A_CT, 16'h0200);
        wr(A_CT, 16'h0000);
        rchk("cleared", A_CT, 16'hc000, 16'h8000);
        evchk("clr_pulse", 4, 16'h0001);
        wr(A_CF, 16'h0003);
        bpulse(0);
        bpulse(0);
        rchk("dbl_full", A_CT, 16'hc000, 16'h4000);
        bpulse(1);
        rchk("dbl_one", A_CT, 16'hc000, 16'hc000);
        bpulse(1);
        rchk("dbl_sent", A_CT, 16'hc000, 16'h8000);
        wr(A_CF, 16'h0000);
        strobe(3);
        rchk("rx_full", A_CT, 16'hc000, 16'hc000);
        bpulse(2);
        rchk("rx_read", A_CT, 16'hc000, 16'h0000);
        wr(A_CF, 16'h0004);
        strobe(3);
        bpulse(2);
        rchk("rx_held", A_CT, 16'hc000, 16'hc000);
        bpulse(3);
        rchk("rx_clr", A_CT, 16'hc000, 16'h0000);
        reset_dut();
        wr(A_CF, 16'h0001);
        bpulse(0);
        wr(A_CT, 16'h0001);
        snap();
        strobe(0);
        rchk("busy", A_CT, 16'h0060, 16'h0020);
        strobe(1);
        rchk("done", A_CT, 16'h0060, 16'h0040);
        evchk("tx_empty_ev", 3, 16'h0001);
        wr(A_CT, 16'h0100);
        rchk("force0", A_CT, 16'h01c0, 16'h0000);
        wr(A_CT, 16'h0080);
        rchk("force1", A_CT, 16'h01c0, 16'h0040);
        wr(A_CF, 16'h0000);
        wr(A_CT, 16'h0001);
        snap();
        xfer(1'h0, 1'h1, 3);
        rchk("pid_bad", A_CT, 16'h0060, 16'h0040);
        evchk("rx_ready_ev", 2, 16'h0001);
        bpulse(2);
        xfer(1'h1, 1'h1, 0);
        rchk("pid_ok", A_CT, 16'h0060, 16'h0000);
        strobe(4);
        rchk("oversize", A_CT, 16'h0003, 16'h0003);
        wr(A_CT, 16'h0002);
        wr(A_CT, 16'h0000);
        wr(A_CT, 16'h0001);
        strobe(6);
        rchk("bus_rst", A_CT, 16'h0003, 16'h0000);
        wr(A_CF, 16'h0008);
        wr(A_CT, 16'h0001);
        strobe(2);
        strobe(2);
        rchk("err_two", A_CT, 16'h0003, 16'h0001);
        strobe(2);
        rchk("err_three", A_CT, 16'h0003, 16'h0000);
        wr(A_CT, 16'h0001);
        strobe(5);
        rchk("stall_hs", A_CT, 16'h0003, 16'h0003);
        reset_dut();
        wr(A_CF, 16'h0001);
        wr(A_CT, 16'h0401);
        snap();
        xfer(1'h0, 1'h0, 2);
        rchk("auto_in", A_CT, 16'h0040, 16'h0040);
        evchk("zero_len", 0, 16'h0001);
        evchk("no_ready", 2, 16'h0000);
        evchk("no_empty", 3, 16'h0000);
        wr(A_CF, 16'h0000);
        snap();
        tok_chk(upr_pkg::HS_NAK);
        evchk("not_ready", 1, 16'h0001);
        print_verdict();
    end
endmodule : test_usb_pipe_response_control
